// ==== frisr_defs.vh ====
`ifndef FRISR_DEFS_VH
`define FRISR_DEFS_VH
// register address
`define FRISR_ADDR_INPUT_CFG 10'h3F7
// compatibility layouts
`define FRISR_MODE_BASIC 2'h0
`define FRISR_MODE_SECOND 2'h1
`define FRISR_MODE_THIRD 2'h2
// config control fields
`define FRISR_CCR_RATE_LSB 0
`define FRISR_CCR_PRECOMP_BIT 2
// rate encodings
`define FRISR_RATE_500K 2'h0
`define FRISR_RATE_300K 2'h1
`define FRISR_RATE_250K 2'h2
`define FRISR_RATE_1M 2'h3
// reset values
`define FRISR_RATE_RESET 2'h2
`define FRISR_PRECOMP_RESET 1'h0
`define FRISR_DENSITY_RESET 1'h1
`define FRISR_LOW_RATE_RESET 1'h1
// cable pins idle high, so the synchroniser starts there
`define FRISR_PIN_IDLE 2'h3
// termination codes
`define FRISR_TERM_NORMAL 2'h0
`define FRISR_TERM_ABNORMAL 2'h1
`define FRISR_TERM_INVALID 2'h2
`define FRISR_TERM_POLLING 2'h3
// status byte zero fields
`define FRISR_ST0_TERM_LSB 6
`define FRISR_ST0_SEEK_BIT 5
`define FRISR_ST0_EQUIP_BIT 4
`define FRISR_ST0_HEAD_BIT 2
// recalibrate step limit
`define FRISR_RECAL_STEPS 7'h50
`endif

// ==== frisr_sync.v ====
`timescale 1ns/10ps
// three-stage pin synchroniser; output changes when stages two and three agree
module frisr_sync (
  // clock and reset
  input wire clk_in,
  input wire rst_n_in,
  input wire [1:0] rst_val_in,
  // pins
  input wire [1:0] pin_in,
  output reg [1:0] pin_out
);
  reg [1:0] s1_q;
  reg [1:0] s2_q;
  reg [1:0] s3_q;
  // first stage feeds only the second
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      s1_q <= rst_val_in;
      s2_q <= rst_val_in;
      s3_q <= rst_val_in;
      pin_out <= rst_val_in;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      pin_out <= (pin_out & (s2_q ^ s3_q)) | (s3_q & ~(s2_q ^ s3_q));
    end
  end
endmodule

// ==== frisr_status0.v ====
`timescale 1ns/10ps
`include "frisr_defs.vh"
// builds the first result status byte from the command outcome
module frisr_status0 (
  // outcome fields
  input wire [1:0] term_code_in,
  input wire seek_end_in,
  input wire recal_fail_in,
  input wire rel_seek_past_zero_in,
  input wire head_in,
  input wire [1:0] drive_in,
  // encoded byte
  output wire [7:0] status_out
);
  // bit 3 is unused and stays zero
  assign status_out = {term_code_in, seek_end_in, recal_fail_in | rel_seek_past_zero_in,
                       1'b0, head_in, drive_in};
endmodule

// ==== frisr_top.v ====
`timescale 1ns/10ps
`include "frisr_defs.vh"
module frisr_top (
  // clock and reset
  input wire clk_in,
  input wire rst_n_in,
  // host register port
  input wire [9:0] addr_in,
  input wire rd_strobe_in,
  input wire wr_strobe_in,
  input wire [7:0] wdata_in,
  output reg [7:0] rdata_out,
  output reg [7:0] rdata_oe_out,
  // configuration
  input wire [1:0] mode_in,
  input wire [1:0] force_disk_change_cfg_in,
  input wire dma_gate_enable_in,
  input wire soft_reset_in,
  // drive cable pins
  input wire disk_change_pin_in,
  input wire track_zero_pin_in,
  output reg density_select_pin_out,
  output reg [1:0] rate_select_out,
  // command engine result
  input wire result_load_in,
  input wire [1:0] term_code_in,
  input wire seek_end_in,
  input wire recal_fail_in,
  input wire rel_seek_past_zero_in,
  input wire head_in,
  input wire [1:0] drive_in,
  output reg [7:0] status0_out,
  output reg low_rate_flag_out
);
  // register state and their next values
  reg [1:0] rate_q;
  reg [1:0] rate_d;
  reg precomp_q;
  reg precomp_d;
  reg [1:0] mode_q;
  reg [1:0] mode_d;
  // output next values
  reg [1:0] rate_out_d;
  reg low_rate_d;
  reg density_d;
  reg [7:0] status0_d;
  reg [7:0] rdata_d;
  reg [7:0] rdata_oe_d;
  // register layout and decode
  reg [7:0] dir_d;
  reg [7:0] oe_d;
  reg disk_change_flag;
  wire [1:0] pins_sync;
  wire [7:0] st0_enc;
  wire rd_hit;
  wire wr_hit;
  wire idle;
  genvar g;

  // slow rates raise the low-rate flag
  function is_low_rate;
    input [1:0] r;
    begin
      is_low_rate = (r == `FRISR_RATE_250K) || (r == `FRISR_RATE_300K);
    end
  endfunction

  // density pin is high for the two fast rates
  function density_for_rate;
    input [1:0] r;
    begin
      density_for_rate = ~is_low_rate(r);
    end
  endfunction

  // one strobe qualified by the shared address; used for reads and writes
  function addr_hit;
    input strobe;
    input [9:0] a;
    begin
      addr_hit = strobe && (a == `FRISR_ADDR_INPUT_CFG);
    end
  endfunction

  // the unused fourth code folds into basic, so only three layouts are stored
  function [1:0] mode_norm;
    input [1:0] m;
    begin
      case (m)
        `FRISR_MODE_SECOND: begin
          mode_norm = `FRISR_MODE_SECOND;
        end
        `FRISR_MODE_THIRD: begin
          mode_norm = `FRISR_MODE_THIRD;
        end
        default: begin
          mode_norm = `FRISR_MODE_BASIC;
        end
      endcase
    end
  endfunction

  // basic layout: only the change bit carries data
  function [7:0] dir_basic;
    input chg;
    begin
      dir_basic = {chg, 7'h00};
    end
  endfunction

  // second layout: ones above the rate, low-rate flag at bit 0
  function [7:0] dir_second;
    input chg;
    input [1:0] r;
    begin
      dir_second = {chg, 4'hF, r, is_low_rate(r)};
    end
  endfunction

  // third layout: zeros above the dma gate, precomp and rate below
  function [7:0] dir_third;
    input chg;
    input dma;
    input pre;
    input [1:0] r;
    begin
      dir_third = {chg, 3'h0, dma, pre, r};
    end
  endfunction

  // drive enables per layout; basic leaves lines 6-0 floating
  function [7:0] oe_for_mode;
    input [1:0] m;
    begin
      case (m)
        `FRISR_MODE_BASIC: begin
          oe_for_mode = 8'h80;
        end
        `FRISR_MODE_SECOND: begin
          oe_for_mode = 8'hFF;
        end
        `FRISR_MODE_THIRD: begin
          oe_for_mode = 8'hFF;
        end
        default: begin
          oe_for_mode = 8'h80;
        end
      endcase
    end
  endfunction

  // the precomp bit exists only in the third layout
  function has_precomp;
    input [1:0] m;
    begin
      has_precomp = (m == `FRISR_MODE_THIRD);
    end
  endfunction

  // pins start at their idle level so reset shows no false disk change
  frisr_sync u_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .rst_val_in(`FRISR_PIN_IDLE),
    .pin_in({track_zero_pin_in, disk_change_pin_in}),
    .pin_out(pins_sync)
  );

  // result encoding is pure logic; the byte is registered below
  frisr_status0 u_st0 (
    .term_code_in(term_code_in),
    .seek_end_in(seek_end_in),
    .recal_fail_in(recal_fail_in),
    .rel_seek_past_zero_in(rel_seek_past_zero_in),
    .head_in(head_in),
    .drive_in(drive_in),
    .status_out(st0_enc)
  );

  // shared address split by strobe
  assign rd_hit = addr_hit(rd_strobe_in, addr_in);
  assign wr_hit = addr_hit(wr_strobe_in, addr_in);
  assign idle = !rd_strobe_in && !wr_strobe_in;

  // force setting: 00 follows pin, 01 forces 0, 1x forces 1
  always @* begin
    case (force_disk_change_cfg_in)
      2'h0: begin
        disk_change_flag = ~pins_sync[0];
      end
      2'h1: begin
        disk_change_flag = 1'h0;
      end
      default: begin
        disk_change_flag = 1'h1;
      end
    endcase
  end

  // layout of the input register by mode
  always @* begin
    dir_d = 8'h00;
    oe_d = 8'h00;
    case (mode_q)
      `FRISR_MODE_BASIC: begin
        dir_d = dir_basic(disk_change_flag);
      end
      `FRISR_MODE_SECOND: begin
        dir_d = dir_second(disk_change_flag, rate_q);
      end
      `FRISR_MODE_THIRD: begin
        dir_d = dir_third(disk_change_flag, dma_gate_enable_in, precomp_q, rate_q);
      end
      default: begin
        dir_d = dir_basic(disk_change_flag);
      end
    endcase
    oe_d = oe_for_mode(mode_q);
  end

  // mode moves only while no access is under way, so layout stays steady
  always @* begin
    mode_d = mode_q;
    if (idle) begin
      mode_d = mode_norm(mode_in);
    end
  end

  // mode register
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      mode_q <= `FRISR_MODE_BASIC;
    end else begin
      mode_q <= mode_d;
    end
  end

  // config next value; reserved bits dropped, soft reset has no say here
  always @* begin
    rate_d = rate_q;
    precomp_d = precomp_q;
    if (wr_hit) begin
      rate_d = wdata_in[`FRISR_CCR_RATE_LSB +: 2];
      if (has_precomp(mode_q)) begin
        precomp_d = wdata_in[`FRISR_CCR_PRECOMP_BIT];
      end
    end
  end

  // config register; only a hard reset reloads it
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      rate_q <= `FRISR_RATE_RESET;
      precomp_q <= `FRISR_PRECOMP_RESET;
    end else begin
      rate_q <= rate_d;
      precomp_q <= precomp_d;
    end
  end

  // read data for the coming cycle; nothing driven unless the register is read
  always @* begin
    rdata_d = 8'h00;
    rdata_oe_d = 8'h00;
    if (rd_hit) begin
      rdata_d = dir_d & oe_d;
      rdata_oe_d = oe_d;
    end
  end

  // one flop pair per data line, so each enable sits beside its data
  generate
    for (g = 0; g < 8; g = g + 1) begin : gen_rd
      always @(posedge clk_in) begin
        if (!rst_n_in) begin
          rdata_out[g] <= 1'h0;
          rdata_oe_out[g] <= 1'h0;
        end else begin
          rdata_out[g] <= rdata_d[g];
          rdata_oe_out[g] <= rdata_oe_d[g];
        end
      end
    end
  endgenerate

  // pin next values follow the stored rate
  always @* begin
    rate_out_d = rate_q;
    low_rate_d = is_low_rate(rate_q);
    density_d = density_for_rate(rate_q);
  end

  // density pin ignores soft reset; only hard reset forces it high
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      density_select_pin_out <= `FRISR_DENSITY_RESET;
      rate_select_out <= `FRISR_RATE_RESET;
      low_rate_flag_out <= `FRISR_LOW_RATE_RESET;
    end else begin
      density_select_pin_out <= density_d;
      rate_select_out <= rate_out_d;
      low_rate_flag_out <= low_rate_d;
    end
  end

  // a load in the same cycle as soft reset wins, so no outcome is lost
  always @* begin
    status0_d = status0_out;
    if (result_load_in) begin
      status0_d = st0_enc;
    end else if (soft_reset_in) begin
      status0_d = 8'h00;
    end
  end

  // held until the next load or soft reset so the host can read it at leisure
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      status0_out <= 8'h00;
    end else begin
      status0_out <= status0_d;
    end
  end
endmodule

// ==== frisr_top_asserts.sv ====
`timescale 1ns/10ps
module frisr_top_asserts (
  // clock, reset, host port
  input wire clk_in,
  input wire rst_n_in,
  input wire [9:0] addr_in,
  input wire rd_strobe_in,
  input wire wr_strobe_in,
  input wire [7:0] wdata_in,
  input wire [7:0] rdata_out,
  input wire [7:0] rdata_oe_out,
  // configuration and results
  input wire [1:0] mode_in,
  input wire dma_gate_enable_in,
  input wire [1:0] force_disk_change_cfg_in,
  input wire density_select_pin_out,
  input wire [1:0] rate_select_out,
  input wire [7:0] status0_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // address decode shared by the properties
  wire rd = rd_strobe_in && addr_in == 10'h3F7;
  wire wr = wr_strobe_in && addr_in == 10'h3F7;
  wire [1:0] w_rate = wdata_in[1:0];
  property p_idle; !rd |=> rdata_oe_out == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("bus driven without read");
  property p_basic; rd && mode_in == 2'h0 |=> rdata_oe_out == 8'h80; endproperty
  a_basic: assert property (p_basic) else $error("basic layout enables");
  property p_second;
    rd && mode_in == 2'h1 && !$past(wr_strobe_in) |=>
      rdata_out[6:0] == {4'hF, rate_select_out, !density_select_pin_out};
  endproperty
  a_second: assert property (p_second) else $error("second layout bits");
  property p_third;
    rd && mode_in == 2'h2 |=> rdata_out[6:3] == {3'h0, $past(dma_gate_enable_in)};
  endproperty
  a_third: assert property (p_third) else $error("third layout bits");
  property p_force; (force_disk_change_cfg_in[1]) [*4] ##0 rd |=> rdata_out[7]; endproperty
  a_force: assert property (p_force) else $error("forced change bit");
  property p_st0; status0_out[3] == 1'b0; endproperty
  a_st0: assert property (p_st0) else $error("status bit three set");
  // rate and density land two edges after the write
  property p_wr;
    wr |=> ##1 rate_select_out == $past(w_rate, 2) &&
      density_select_pin_out == ($past(w_rate, 2) == 2'h0 || $past(w_rate, 2) == 2'h3);
  endproperty
  a_wr: assert property (p_wr) else $error("rate write not applied");
  property p_rst;
    disable iff (1'b0) !rst_n_in ##1 !rst_n_in |=>
      rate_select_out == 2'h2 && density_select_pin_out;
  endproperty
  a_rst: assert property (p_rst) else $error("hard reset values");
endmodule
bind frisr_top frisr_top_asserts u_frisr_top_asserts (.*);

// ==== frisr_drive_model.sv ====
`timescale 1ns/10ps
module frisr_drive_model (
  // bench control
  input wire clk_in,
  input wire door_open_in,
  // cable pins
  output reg disk_change_pin_out,
  output reg track_zero_pin_out
);
  // pins move off the host edge, like a slow cable
  always @(negedge clk_in) begin
    disk_change_pin_out <= !door_open_in;
    track_zero_pin_out <= 1'h1;
  end
endmodule

// ==== test_floppy_rate_input_status_regs.sv ====
`timescale 1ns/10ps
module test_floppy_rate_input_status_regs;
  reg clk_in = 0, rst_n_in = 0, rd_strobe_in = 0, wr_strobe_in = 0, dma_gate_enable_in = 0;
  reg soft_reset_in = 0, result_load_in = 0, seek_end_in = 0, recal_fail_in = 0;
  reg rel_seek_past_zero_in = 0, head_in = 0, door = 0;
  reg [9:0] addr_in = 10'h000;
  reg [7:0] wdata_in = 8'h00;
  reg [1:0] mode_in = 2'h1, force_disk_change_cfg_in = 2'h0, term_code_in = 2'h0, drive_in = 2'h0;
  wire [7:0] rdata_out, rdata_oe_out, status0_out;
  wire [1:0] rate_select_out;
  wire density_select_pin_out, low_rate_flag_out, disk_change_pin_in, track_zero_pin_in;
  integer n_fail = 0, checks_done = 0, i;
  reg f;
  frisr_top u_frisr_top (.*);
  frisr_drive_model u_frisr_drive_model (.clk_in(clk_in), .door_open_in(door),
    .disk_change_pin_out(disk_change_pin_in), .track_zero_pin_out(track_zero_pin_in));
  initial forever #5 clk_in = !clk_in;
  task cyc(input integer n); repeat (n) @(negedge clk_in); endtask
  task chk(input [63:0] nm, input [7:0] e, input [7:0] g);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("mismatch %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // one strobe cycle; read data is settled at the closing falling edge
  task acc(input w, input [9:0] a, input [7:0] d);
    begin
      addr_in = a;
      wdata_in = d;
      if (w) wr_strobe_in = 1;
      else rd_strobe_in = 1;
      cyc(1);
      wr_strobe_in = 0;
      rd_strobe_in = 0;
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  // main sequence
  initial begin
    cyc(6);
    rst_n_in = 1;
    cyc(1);
    acc(0, 10'h3F7, 0);
    chk("dir", 8'h7D, rdata_out);
    chk("oe", 8'hFF, rdata_oe_out);
    for (i = 0; i < 4; i = i + 1) begin
      f = (i == 0 || i == 3);
      acc(1, 10'h3F7, i);
      cyc(1);
      chk("rate", {4'h0, i[1:0], f, !f}, {4'h0, rate_select_out, density_select_pin_out,
        low_rate_flag_out});
      acc(0, 10'h3F7, 0);
      chk("dir", {4'h7, 1'b1, i[1:0], !f}, rdata_out);
    end
    mode_in = 2'h2;
    dma_gate_enable_in = 1;
    cyc(1);
    acc(1, 10'h3F7, 8'h05);
    acc(0, 10'h3F7, 0);
    chk("dir", 8'h0D, rdata_out);
    soft_reset_in = 1;
    cyc(1);
    soft_reset_in = 0;
    acc(0, 10'h3F7, 0);
    chk("soft", 8'h0D, rdata_out);
    chk("dens", 8'h00, density_select_pin_out);
    mode_in = 2'h0;
    force_disk_change_cfg_in = 2'h2;
    cyc(4);
    acc(0, 10'h3F7, 0);
    chk("oe", 8'h80, rdata_oe_out);
    chk("force", 8'h80, rdata_out & 8'h80);
    force_disk_change_cfg_in = 2'h0;
    door = 1;
    cyc(6);
    acc(0, 10'h3F7, 0);
    chk("pin", 8'h80, rdata_out & 8'h80);
    cyc(1);
    acc(0, 10'h3F5, 0);
    chk("unmap", 8'h00, rdata_oe_out);
    mode_in = 2'h3;
    cyc(1);
    acc(0, 10'h3F7, 0);
    chk("oe3", 8'h80, rdata_oe_out);
    // every termination code, varied side fields
    for (i = 0; i < 4; i = i + 1) begin
      {term_code_in, drive_in, seek_end_in, head_in} = {i[1:0], i[1:0], i[0], i[0]};
      {recal_fail_in, rel_seek_past_zero_in} = {i == 1, i == 2};
      result_load_in = 1;
      cyc(1);
      result_load_in = 0;
      chk("st0", {i[1:0], i[0], i == 1 || i == 2, 1'b0, i[0], i[1:0]}, status0_out);
      cyc(1);
    end
    soft_reset_in = 1;
    cyc(1);
    soft_reset_in = 0;
    chk("st0clr", 8'h00, status0_out);
    rst_n_in = 0;
    cyc(2);
    rst_n_in = 1;
    chk("hard", 8'h05, {rate_select_out, density_select_pin_out});
    final_report;
  end
endmodule
